//--- core/alc_linearity_regs.sv
`timescale 1ns/1ps
module alc_linearity_regs (
   input  wire logic         core_clk,
   input  wire logic         resetn,
   // classic wishbone slave; byte address, word index in [17:2]: [17:10] page, [9:2] offset
   input  wire logic [17:0]  wb_adr_i,
   input  wire logic [31:0]  wb_dat_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic         wb_we_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   // analog-side controls
   output logic      [7:0]   fast_overrange_threshold,
   output logic              fixed_one_level,
   output alc_pkg::alc_chan_t harmonic_active
);
   alc_pkg::alc_req_t req;          // decoded request
   logic [7:0] fixed_q,  fixed_d;   // master fixed-one register
   logic [7:0] fovr_q,   fovr_d;    // threshold
   logic [7:0] cstb_q,   cstb_d;    // channel C strobe register
   logic [7:0] cdctl_q,  cdctl_d;   // C/D control
   logic [7:0] astb_q,   astb_d;    // channel A strobe register
   logic [7:0] abctl_q,  abctl_d;   // A/B control
   logic       ack_q,    ack_d;     // bus answer
   logic [31:0] rdat_q,  rdat_d;    // read data

   // address decode: word index byte address = 4 * index, so adr[1:0] carry nothing here
   always_comb begin
      req.valid = wb_cyc_i && wb_stb_i && !ack_q;
      req.write = wb_we_i;
      req.page  = wb_adr_i[17:10];
      req.ofs   = wb_adr_i[9:2];
      req.wdata = wb_dat_i[7:0];
      req.lane0 = wb_sel_i[0];
   end

   // one register hit test, used by every write and the read mux
   function automatic logic hit(input alc_pkg::alc_req_t r, input logic [7:0] pg, input logic [7:0] of);
      hit = (r.page == pg) && (r.ofs == of);
   endfunction

   // masked write: reserved bits are never stored so they read zero
   function automatic logic [7:0] wr(input logic [7:0] old, input alc_pkg::alc_req_t r,
                                     input logic [7:0] mask);
      wr = (r.valid && r.write && r.lane0) ? (r.wdata & mask) : old;
   endfunction

   // register next values; the host is trusted to write the fixed bit as one
   always_comb begin
      fixed_d = fixed_q;
      fovr_d  = fovr_q;
      cstb_d  = cstb_q;
      cdctl_d = cdctl_q;
      astb_d  = astb_q;
      abctl_d = abctl_q;
      if (hit(req, alc_pkg::PAGE_MASTER, alc_pkg::OFS_FIXED_ONE))
         fixed_d = wr(fixed_q, req, alc_pkg::MASK_FIXED_ONE);
      if (hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_FOVR_LEVEL))
         fovr_d = wr(fovr_q, req, alc_pkg::MASK_FOVR);
      if (hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_C_STROBE))
         cstb_d = wr(cstb_q, req, alc_pkg::MASK_HI_STROBE);
      if (hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_CD_CTL))
         cdctl_d = wr(cdctl_q, req, alc_pkg::MASK_PAIR_CTL);
      if (hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_A_STROBE))
         astb_d = wr(astb_q, req, alc_pkg::MASK_HI_STROBE);
      if (hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_AB_CTL))
         abctl_d = wr(abctl_q, req, alc_pkg::MASK_PAIR_CTL);
   end

   // bus answer: one wait-free cycle, ack the edge after the request is seen
   always_comb begin
      ack_d  = req.valid;
      rdat_d = alc_pkg::RD_UNMAPPED;
      if (req.valid && !req.write) begin
         unique case (1'b1)
            hit(req, alc_pkg::PAGE_MASTER, alc_pkg::OFS_FIXED_ONE):  rdat_d[7:0] = fixed_q;
            hit(req, alc_pkg::PAGE_CONV,   alc_pkg::OFS_FOVR_LEVEL): rdat_d[7:0] = fovr_q;
            hit(req, alc_pkg::PAGE_CONV,   alc_pkg::OFS_C_STROBE):   rdat_d[7:0] = cstb_q;
            hit(req, alc_pkg::PAGE_CONV,   alc_pkg::OFS_CD_CTL):     rdat_d[7:0] = cdctl_q;
            hit(req, alc_pkg::PAGE_CONV,   alc_pkg::OFS_A_STROBE):   rdat_d[7:0] = astb_q;
            hit(req, alc_pkg::PAGE_CONV,   alc_pkg::OFS_AB_CTL):     rdat_d[7:0] = abctl_q;
            default:                                                  rdat_d = alc_pkg::RD_UNMAPPED;
         endcase
      end
   end

   // all state zero at reset
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fixed_q <= alc_pkg::REG_RESET;
         fovr_q  <= alc_pkg::REG_RESET;
         cstb_q  <= alc_pkg::REG_RESET;
         cdctl_q <= alc_pkg::REG_RESET;
         astb_q  <= alc_pkg::REG_RESET;
         abctl_q <= alc_pkg::REG_RESET;
         ack_q   <= 1'b0;
         rdat_q  <= alc_pkg::RD_UNMAPPED;
      end else begin
         fixed_q <= fixed_d;
         fovr_q  <= fovr_d;
         cstb_q  <= cstb_d;
         cdctl_q <= cdctl_d;
         astb_q  <= astb_d;
         abctl_q <= abctl_d;
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
      end
   end

   assign wb_ack_o                 = ack_q;
   assign wb_dat_o                 = rdat_q;
   assign fast_overrange_threshold = fovr_q;
   assign fixed_one_level          = fixed_q[alc_pkg::BIT_FIXED_ONE];

   // per-channel arming; enable bit of each pair gates both of its strobes
   alc_strobe_arm u_arm_c (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .pair_en    (cdctl_q[alc_pkg::BIT_PAIR_EN]),
      .strobe_bit (cstb_q[alc_pkg::BIT_HI_STROBE]),
      .active     (harmonic_active.chan_c)
   );
   alc_strobe_arm u_arm_d (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .pair_en    (cdctl_q[alc_pkg::BIT_PAIR_EN]),
      .strobe_bit (cdctl_q[alc_pkg::BIT_LO_STROBE]),
      .active     (harmonic_active.chan_d)
   );
   alc_strobe_arm u_arm_a (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .pair_en    (abctl_q[alc_pkg::BIT_PAIR_EN]),
      .strobe_bit (astb_q[alc_pkg::BIT_HI_STROBE]),
      .active     (harmonic_active.chan_a)
   );
   alc_strobe_arm u_arm_b (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .pair_en    (abctl_q[alc_pkg::BIT_PAIR_EN]),
      .strobe_bit (abctl_q[alc_pkg::BIT_LO_STROBE]),
      .active     (harmonic_active.chan_b)
   );

   a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   a_thresh_written: assert property (@(posedge core_clk) disable iff (!resetn)
      req.valid && req.write && req.lane0 && hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_FOVR_LEVEL)
      |=> fast_overrange_threshold == $past(wb_dat_i[7:0]))
      else $error("threshold not updated by write");
   a_fixed_page: assert property (@(posedge core_clk) disable iff (!resetn)
      $changed(fixed_q) |-> $past(req.page) == alc_pkg::PAGE_MASTER)
      else $error("fixed register changed from wrong page");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      (cdctl_q & ~alc_pkg::MASK_PAIR_CTL) == 8'h00 && (fixed_q & ~alc_pkg::MASK_FIXED_ONE) == 8'h00)
      else $error("reserved bit stored");
   a_ab_needs_en: assert property (@(posedge core_clk) disable iff (!resetn)
      !abctl_q[alc_pkg::BIT_PAIR_EN] |=> !harmonic_active.chan_a && !harmonic_active.chan_b)
      else $error("A/B improvement active without enable");
   a_cd_needs_en: assert property (@(posedge core_clk) disable iff (!resetn)
      !cdctl_q[alc_pkg::BIT_PAIR_EN] |=> !harmonic_active.chan_c && !harmonic_active.chan_d)
      else $error("C/D improvement active without enable");
   a_reset_zero: assert property (@(posedge core_clk)
      !resetn |=> fovr_q == 8'h00 && fixed_q == 8'h00 && !wb_ack_o)
      else $error("register not zero after reset");
   a_read_back: assert property (@(posedge core_clk) disable iff (!resetn)
      req.valid && !req.write && hit(req, alc_pkg::PAGE_CONV, alc_pkg::OFS_FOVR_LEVEL)
      |=> wb_ack_o && wb_dat_o[7:0] == fovr_q)
      else $error("read data differs from stored threshold");
endmodule // alc_linearity_regs

//--- core/alc_pkg.sv
package alc_pkg;
   // bus geometry
   localparam int unsigned ADDR_W = 10;          // byte address width within a page, offset in [9:2]; page in [17:10]... see page decode
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;

   // page codes, carried in address bits [15:8] of the word index space
   localparam logic [7:0] PAGE_MASTER = 8'h80;
   localparam logic [7:0] PAGE_CONV   = 8'h0F;

   // register offsets within a page (printed offsets are not all multiples of four: index, byte = 4*index)
   localparam logic [7:0] OFS_FIXED_ONE  = 8'h59;
   localparam logic [7:0] OFS_FOVR_LEVEL = 8'h5F;
   localparam logic [7:0] OFS_C_STROBE   = 8'h60;
   localparam logic [7:0] OFS_CD_CTL     = 8'h61;
   localparam logic [7:0] OFS_A_STROBE   = 8'h6C;
   localparam logic [7:0] OFS_AB_CTL     = 8'h6D;

   // field positions
   localparam int unsigned BIT_FIXED_ONE = 5;
   localparam int unsigned BIT_HI_STROBE = 7;
   localparam int unsigned BIT_PAIR_EN   = 3;
   localparam int unsigned BIT_LO_STROBE = 0;

   // reset value of every register
   localparam logic [7:0] REG_RESET = 8'h00;

   // writable masks: everything else reads back zero
   localparam logic [7:0] MASK_FIXED_ONE = 8'h20;
   localparam logic [7:0] MASK_FOVR      = 8'hFF;
   localparam logic [7:0] MASK_HI_STROBE = 8'h80;
   localparam logic [7:0] MASK_PAIR_CTL  = 8'h09;

   // answer to an unmapped word
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

   // per-channel harmonic improvement state seen by the analog side
   typedef struct packed {
      logic chan_a;
      logic chan_b;
      logic chan_c;
      logic chan_d;
   } alc_chan_t;

   // decoded bus request
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] page;
      logic [7:0] ofs;
      logic [7:0] wdata;
      logic       lane0;
   } alc_req_t;
endpackage

//--- core/alc_strobe_arm.sv
`timescale 1ns/1ps
// one channel: the improvement is armed on the falling edge of the strobe bit while the pair enable is set
module alc_strobe_arm (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic pair_en,
   input  wire logic strobe_bit,
   output logic      active
);
   logic strobe_q;   // last seen strobe bit
   logic strobe_d;
   logic armed_q;    // improvement applied
   logic armed_d;

   // a completed 1-then-0 pulse with the pair enabled arms; dropping the enable disarms
   always_comb begin
      strobe_d = strobe_bit;
      armed_d  = armed_q;
      if (!pair_en) begin
         armed_d = 1'b0;
      end else if (strobe_q && !strobe_bit) begin
         armed_d = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         strobe_q <= 1'b0;
         armed_q  <= 1'b0;
      end else begin
         strobe_q <= strobe_d;
         armed_q  <= armed_d;
      end
   end

   assign active = armed_q;

   a_arm_needs_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(armed_q) |-> $past(strobe_q) && !$past(strobe_bit) && $past(pair_en))
      else $error("improvement armed without a completed strobe pulse");
endmodule // alc_strobe_arm

//--- bench/tb_alc_linearity_regs.sv
`timescale 1ns/1ps
// register readback, page decode, reset and strobe arming, driven over classic wishbone
module tb_alc_linearity_regs;
   typedef struct packed {
      logic [7:0] page;                       // page code of the word
      logic [7:0] ofs;                        // offset within the page
      logic [7:0] wdat;                       // value written
      logic [7:0] exp;                        // value read back
   } alc_row_t;
   logic              core_clk = 1'b0;        // 250 MHz
   logic              resetn   = 1'b0;        // sync, active low
   logic [17:0]       wb_adr_i = '0;
   logic [31:0]       wb_dat_i = '0;
   logic [3:0]        wb_sel_i = '0;
   logic              wb_we_i  = 1'b0;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o;
   logic [7:0]        fast_overrange_threshold;
   logic              fixed_one_level;
   alc_pkg::alc_chan_t harmonic_active;
   int                error_cnt  = 0;
   int                n_compared = 0;
   logic [31:0]       rd;
   // unmapped rows (wrong page) must read zero and leave the mapped ones alone
   // host writes keep the fixed bit one and reserved bits zero; a pair enable goes in before its strobe
   alc_row_t rows [8] = '{'{8'h80, 8'h59, 8'h20, 8'h20}, '{8'h0F, 8'h5F, 8'hA5, 8'hA5},
                          '{8'h0F, 8'h61, 8'h08, 8'h08}, '{8'h0F, 8'h60, 8'h80, 8'h80},
                          '{8'h0F, 8'h6C, 8'h00, 8'h00}, '{8'h0F, 8'h6D, 8'h08, 8'h08},
                          '{8'h0F, 8'h59, 8'hFF, 8'h00}, '{8'h80, 8'h5F, 8'hFF, 8'h00}};
   logic [7:0] offs [6] = '{8'h59, 8'h5F, 8'h60, 8'h61, 8'h6C, 8'h6D};

   always #2 core_clk = ~core_clk;

   alc_linearity_regs dut_u (.core_clk(core_clk), .resetn(resetn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .fast_overrange_threshold(fast_overrange_threshold),
      .fixed_one_level(fixed_one_level), .harmonic_active(harmonic_active));

   task summarize;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; the wait is bounded so a silent slave cannot hang the run
   task automatic wb(input logic we, input logic [7:0] pg, input logic [7:0] ofs, input logic [7:0] wd,
                     input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {pg, ofs, 2'b00};
      wb_dat_i <= {24'h0, wd};
      wb_sel_i <= sel;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
      wb(1'b1, 8'h0F, ofs, wd, 4'hF);
   endtask

   // lets the arming logic settle after the closing write
   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   initial begin
      #40000;
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         wb(1'b1, rows[i].page, rows[i].ofs, rows[i].wdat, 4'hF);
         wb(1'b0, rows[i].page, rows[i].ofs, 8'h00, 4'hF);
         chk(rd, {24'h0, rows[i].exp});
      end
      #1;
      chk({24'h0, fast_overrange_threshold}, 32'h0000_00A5);
      chk({31'h0, fixed_one_level}, 32'h0000_0001);
      $display("test table done");
      // second reset in mid-run: everything back to zero
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk({19'h0, fast_overrange_threshold, fixed_one_level, 4'(harmonic_active)}, 32'h0);
      wb(1'b0, 8'h80, 8'h59, 8'h00, 4'hF);
      chk(rd, 32'h0);
      foreach (offs[i]) begin
         wb(1'b0, 8'h0F, offs[i], 8'h00, 4'hF);
         chk(rd, 32'h0);
      end
      $display("test reset done");
      // byte lane zero off: the write must be dropped
      wb(1'b1, 8'h0F, 8'h5F, 8'h3C, 4'hE);
      wb(1'b0, 8'h0F, 8'h5F, 8'h00, 4'hF);
      chk(rd, 32'h0);
      $display("test lane done");
      // the pair enable alone arms nothing: a strobe pulse is still needed
      wr(8'h6D, 8'h08);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'h0);
      wr(8'h6D, 8'h08);
      wr(8'h6C, 8'h80);
      wr(8'h6C, 8'h00);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'h8);
      wr(8'h6D, 8'h09);
      wr(8'h6D, 8'h08);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'hC);
      wr(8'h61, 8'h08);
      wr(8'h60, 8'h80);
      wr(8'h60, 8'h00);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'hE);
      wr(8'h61, 8'h09);
      wr(8'h61, 8'h08);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'hF);
      // dropping the A/B enable disarms only that pair
      wr(8'h6D, 8'h00);
      settle();
      chk({28'h0, 4'(harmonic_active)}, 32'h3);
      $display("test strobe done");
      summarize();
   end
endmodule // tb_alc_linearity_regs
